// >>> core/pdl_pkg.sv
// shared constants and carrier types for the divider, lock and routing control block
package pdl_pkg;

	// divider bank: four dividers, ratio 2^(k+1) in fine mode, one more stage in coarse mode
	localparam int NUM_DIV = 4;
	localparam int DIV_CNT_W = 5;
	localparam int FINE_FIRST_BIT = 0;
	localparam int COARSE_FIRST_BIT = 1;

	// output groups, each with two outputs sharing one source
	localparam int NUM_GROUPS = 5;
	localparam int OUTS_PER_GROUP = 2;

	// user-programmable pins that may carry the lock indication
	localparam int NUM_USER_PINS = 4;

	// lock qualification range, in reference cycles
	localparam logic [8:0] LOCK_CYC_MIN = 9'h010;
	localparam logic [8:0] LOCK_CYC_MAX = 9'h100;
	localparam logic [8:0] LOCK_CNT_RST = 9'h000;

	// reset values
	localparam logic [DIV_CNT_W-1:0] DIV_CNT_RST = 5'h00;
	localparam logic [1:0] SYNC_RST = 2'h0;

	// lock detector states
	typedef enum logic [1:0]
	{
		PDL_LK_IDLE = 2'b00,
		PDL_LK_QUAL = 2'b01,
		PDL_LK_LOCKED = 2'b10
	} pdl_lock_state_t;

	// routing of one output group
	typedef struct packed
	{
		logic use_ref;
		logic ref_alt;
		logic [1:0] div_sel;
	} pdl_group_route_t;

	// source choices that may come from a user pin or from the serial port
	typedef struct packed
	{
		logic bypass_from_port;
		logic bypass_port;
		logic reference_source_select_from_port;
		logic reference_source_select_port;
	} pdl_ctrl_src_t;

	// feedback path configuration
	typedef struct packed
	{
		logic external;
		logic [1:0] div_sel;
	} pdl_fb_cfg_t;

endpackage

// >>> core/pdl_ctrl.sv
// divider bank, reference and bypass selection, lock detector and output routing matrix
`timescale 1ns/100ps

//////////////////////////////////////////////////////////////////////////////
module pdl_ctrl
(
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,

	// asynchronous pins
	input wire logic primary_ref_input,
	input wire logic alternate_ref_input,
	input wire logic fb_return_input,
	input wire logic freq_lock_det,
	input wire logic bypass_pin,
	input wire logic reference_source_select_pin,

	// oscillator edge, one-cycle enable from the analog loop in this domain
	input wire logic vco_tick,

	// configuration from the serial port, same domain
	input wire pdl_pkg::pdl_ctrl_src_t ctrl_src,
	input wire logic coarse_skew,
	input wire pdl_pkg::pdl_fb_cfg_t fb_cfg,
	input wire logic [7:0] lock_cycles_cfg,
	input wire logic lock_active_high,
	input wire logic lock_pin_en,
	input wire logic [1:0] lock_pin_sel,
	input wire pdl_pkg::pdl_group_route_t [pdl_pkg::NUM_GROUPS-1:0] group_route,

	// clock outputs
	output logic [pdl_pkg::NUM_DIV-1:0] div_out_ff,
	output logic [pdl_pkg::NUM_GROUPS*pdl_pkg::OUTS_PER_GROUP-1:0] group_out_ff,
	output logic fb_clk_ff,

	// status and analog controls
	output logic lock_ind_ff,
	output logic [pdl_pkg::NUM_USER_PINS-1:0] user_pin_out_ff,
	output logic [pdl_pkg::NUM_USER_PINS-1:0] user_pin_oe_ff,
	output logic bypass_active_ff,
	output logic ref_alt_active_ff,
	output logic phase_skew_en_ff,
	output logic fb_phase_skew_en_ff,
	output logic fb_time_skew_en_ff
);

	//////////////////////////////////////////////////////////////////////////////
	// two-flop synchronisers for every pin

	localparam int NUM_SYNC = 6;

	logic [NUM_SYNC-1:0] pin_raw;
	logic [NUM_SYNC-1:0] sync1_ff;
	logic [NUM_SYNC-1:0] sync2_ff;

	assign pin_raw = {reference_source_select_pin, bypass_pin, freq_lock_det, fb_return_input,
		alternate_ref_input, primary_ref_input};

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end
		else
		begin
			sync1_ff <= pin_raw;
			sync2_ff <= sync1_ff;
		end
	end

	logic prim_ref_s;
	logic alt_ref_s;
	logic fb_ret_s;
	logic freq_lock_s;
	logic bypass_pin_s;
	logic reference_source_select_pin_s;

	assign prim_ref_s = sync2_ff[0];
	assign alt_ref_s = sync2_ff[1];
	assign fb_ret_s = sync2_ff[2];
	assign freq_lock_s = sync2_ff[3];
	assign bypass_pin_s = sync2_ff[4];
	assign reference_source_select_pin_s = sync2_ff[5];

	//////////////////////////////////////////////////////////////////////////////
	// bypass and reference selection

	logic bypass_sel;
	logic reference_source_select_sel;

	// a pin or the port drives each choice, never both at once
	assign bypass_sel = ctrl_src.bypass_from_port ? ctrl_src.bypass_port : bypass_pin_s;
	assign reference_source_select_sel = ctrl_src.reference_source_select_from_port ? ctrl_src.reference_source_select_port : reference_source_select_pin_s;

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			bypass_active_ff <= 1'b0;
			ref_alt_active_ff <= 1'b0;
		end
		else
		begin
			bypass_active_ff <= bypass_sel;
			ref_alt_active_ff <= reference_source_select_sel;
		end
	end

	logic act_ref;
	logic act_ref_d_ff;
	logic ref_rise;

	assign act_ref = ref_alt_active_ff ? alt_ref_s : prim_ref_s;

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			act_ref_d_ff <= 1'b0;
		else
			act_ref_d_ff <= act_ref;
	end

	assign ref_rise = act_ref && !act_ref_d_ff;

	//////////////////////////////////////////////////////////////////////////////
	// divider bank

	logic div_tick;
	logic [pdl_pkg::DIV_CNT_W-1:0] div_cnt_ff;
	logic [pdl_pkg::NUM_DIV-1:0] div_level;

	// bypass feeds reference edges in place of oscillator edges
	assign div_tick = bypass_active_ff ? ref_rise : vco_tick;

	// a binary count gives every power-of-two ratio from one register
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			div_cnt_ff <= pdl_pkg::DIV_CNT_RST;
		else if (div_tick)
			div_cnt_ff <= div_cnt_ff + 5'h01;
	end

	genvar gk;
	generate
		for (gk = 0; gk < pdl_pkg::NUM_DIV; gk++)
		begin : g_div
			// coarse mode takes one bit higher: the extra halving stage
			assign div_level[gk] = coarse_skew ?
				div_cnt_ff[gk+pdl_pkg::COARSE_FIRST_BIT] :
				div_cnt_ff[gk+pdl_pkg::FINE_FIRST_BIT];
		end
	endgenerate

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			div_out_ff <= '0;
		else
			div_out_ff <= div_level;
	end

	//////////////////////////////////////////////////////////////////////////////
	// feedback path and skew enables

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			fb_clk_ff <= 1'b0;
		else if (fb_cfg.external)
			fb_clk_ff <= fb_ret_s;
		else
			fb_clk_ff <= div_level[fb_cfg.div_sel];
	end

	// phase skew is derived from the oscillator, so it has no meaning in bypass
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			phase_skew_en_ff <= 1'b0;
			fb_phase_skew_en_ff <= 1'b0;
			fb_time_skew_en_ff <= 1'b0;
		end
		else
		begin
			phase_skew_en_ff <= !bypass_sel;
			fb_phase_skew_en_ff <= !bypass_sel;
			fb_time_skew_en_ff <= fb_cfg.external;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// output routing matrix

	logic [pdl_pkg::NUM_GROUPS-1:0] grp_src;

	genvar gg;
	generate
		for (gg = 0; gg < pdl_pkg::NUM_GROUPS; gg++)
		begin : g_grp
			assign grp_src[gg] = group_route[gg].use_ref ?
				(group_route[gg].ref_alt ? alt_ref_s : prim_ref_s) :
				div_level[group_route[gg].div_sel];
		end
	endgenerate

	// one source per group feeds both outputs, so a pair can never split
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			group_out_ff <= '0;
		else
			for (int g = 0; g < pdl_pkg::NUM_GROUPS; g++)
				group_out_ff[g*2 +: 2] <= {2{grp_src[g]}};
	end

	//////////////////////////////////////////////////////////////////////////////
	// lock detector

	pdl_pkg::pdl_lock_state_t lock_st_ff;
	pdl_pkg::pdl_lock_state_t nxt_lock_st;
	logic [8:0] lock_cnt_ff;
	logic [8:0] lock_need;
	logic lock_ok;
	logic locked;

	// configured count is cycles minus one; below the floor the floor applies
	assign lock_need = ({1'b0, lock_cycles_cfg} + 9'h001 < pdl_pkg::LOCK_CYC_MIN) ?
		pdl_pkg::LOCK_CYC_MIN : ({1'b0, lock_cycles_cfg} + 9'h001);
	assign lock_ok = freq_lock_s && !bypass_sel;
	assign locked = lock_st_ff == pdl_pkg::PDL_LK_LOCKED;

	always_comb
	begin
		nxt_lock_st = lock_st_ff;
		unique case (lock_st_ff)
			pdl_pkg::PDL_LK_IDLE:
				if (lock_ok)
					nxt_lock_st = pdl_pkg::PDL_LK_QUAL;
			pdl_pkg::PDL_LK_QUAL:
				if (!lock_ok)
					nxt_lock_st = pdl_pkg::PDL_LK_IDLE;
				else if (ref_rise && lock_cnt_ff + 9'h001 >= lock_need)
					nxt_lock_st = pdl_pkg::PDL_LK_LOCKED;
			pdl_pkg::PDL_LK_LOCKED:
				if (!lock_ok)
					nxt_lock_st = pdl_pkg::PDL_LK_IDLE;
			default:
				nxt_lock_st = pdl_pkg::PDL_LK_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			lock_st_ff <= pdl_pkg::PDL_LK_IDLE;
		else
			lock_st_ff <= nxt_lock_st;
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			lock_cnt_ff <= pdl_pkg::LOCK_CNT_RST;
		else if (!lock_ok || lock_st_ff != pdl_pkg::PDL_LK_QUAL)
			lock_cnt_ff <= pdl_pkg::LOCK_CNT_RST;
		else if (ref_rise)
			lock_cnt_ff <= lock_cnt_ff + 9'h001;
	end

	// loss of lock acts on the raw condition so the indication falls with the state
	logic lock_now;
	assign lock_now = (nxt_lock_st == pdl_pkg::PDL_LK_LOCKED);

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			lock_ind_ff <= 1'b0;
			user_pin_out_ff <= '0;
			user_pin_oe_ff <= '0;
		end
		else
		begin
			lock_ind_ff <= lock_active_high ? lock_now : !lock_now;
			for (int i = 0; i < pdl_pkg::NUM_USER_PINS; i++)
			begin
				user_pin_oe_ff[i] <= lock_pin_en && (lock_pin_sel == 2'(i));
				user_pin_out_ff[i] <= lock_pin_en && (lock_pin_sel == 2'(i)) &&
					(lock_active_high ? lock_now : !lock_now);
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// checks

	property p_lock_level;
		@(posedge clk) disable iff (!reset_n)
		1'b1 |=> (lock_ind_ff == ($past(lock_active_high) ? locked : !locked));
	endproperty
	a_lock_level: assert property (p_lock_level) else $error("lock level wrong");

	property p_lock_qual;
		@(posedge clk) disable iff (!reset_n)
		(lock_st_ff == pdl_pkg::PDL_LK_QUAL) && (nxt_lock_st == pdl_pkg::PDL_LK_LOCKED)
			|-> (lock_cnt_ff + 9'h001 >= lock_need) && (lock_need >= pdl_pkg::LOCK_CYC_MIN) &&
			(lock_need <= pdl_pkg::LOCK_CYC_MAX);
	endproperty
	a_lock_qual: assert property (p_lock_qual) else $error("lock too early");

	property p_lock_drop;
		@(posedge clk) disable iff (!reset_n)
		locked && !lock_ok |-> ##1 !locked ##0 (lock_ind_ff == !lock_active_high);
	endproperty
	a_lock_drop: assert property (p_lock_drop) else $error("lock not dropped");

	property p_lock_pin;
		@(posedge clk) disable iff (!reset_n)
		$rose(user_pin_oe_ff[0]) |-> ($past(lock_pin_sel) == 2'h0) && $past(lock_pin_en);
	endproperty
	a_lock_pin: assert property (p_lock_pin) else $error("lock pin not selected");

	property p_div_ratio;
		@(posedge clk) disable iff (!reset_n)
		$changed(div_cnt_ff) && !coarse_skew |=> (div_out_ff[0] == $past(div_cnt_ff[0]));
	endproperty
	a_div_ratio: assert property (p_div_ratio) else $error("fine divider wrong");

	property p_coarse;
		@(posedge clk) disable iff (!reset_n)
		coarse_skew |=> (div_out_ff[3] == $past(div_cnt_ff[4]));
	endproperty
	a_coarse: assert property (p_coarse) else $error("coarse divider wrong");

	property p_bypass_cnt;
		@(posedge clk) disable iff (!reset_n)
		bypass_active_ff && !ref_rise |=> $stable(div_cnt_ff);
	endproperty
	a_bypass_cnt: assert property (p_bypass_cnt) else $error("bypass divider ran");

	property p_bypass_nolock;
		@(posedge clk) disable iff (!reset_n)
		bypass_sel |=> !locked && (lock_cnt_ff == pdl_pkg::LOCK_CNT_RST) && !phase_skew_en_ff;
	endproperty
	a_bypass_nolock: assert property (p_bypass_nolock) else $error("bypass kept lock");

	property p_fb_time;
		@(posedge clk) disable iff (!reset_n)
		!fb_cfg.external |=> !fb_time_skew_en_ff;
	endproperty
	a_fb_time: assert property (p_fb_time) else $error("time skew on internal fb");

	property p_group_pair;
		@(posedge clk) disable iff (!reset_n)
		1'b1 |-> (((group_out_ff >> 1) & 10'h155) == (group_out_ff & 10'h155));
	endproperty
	a_group_pair: assert property (p_group_pair) else $error("group outputs differ");

endmodule

// >>> tb/pdl_ref_model.sv
// reference, feedback-return and oscillator sources driving the control block
`timescale 1ns/100ps
module pdl_ref_model
(
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// sources
	output logic ref_a,
	output logic ref_b,
	output logic fb_ret,
	output logic vco
);
	int cnt;
	// distinct rates so a group routed to the wrong reference shows up as a wrong edge count
	always @(negedge clk)
	begin
		cnt = reset_n ? cnt + 1 : 0;
		ref_a <= (cnt % 8) < 4;
		ref_b <= (cnt % 12) < 6;
		fb_ret <= (cnt % 16) < 8;
		vco <= reset_n;
	end
endmodule

// >>> tb/pdl_ctrl_tb.sv
// self-checking bench for the divider, lock and routing control block
`timescale 1ns/100ps
module pdl_ctrl_tb;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic ref_a;
	logic ref_b;
	logic fb_ret;
	logic vco;
	logic freq_lock_det = 1'b0;
	logic bypass_pin = 1'b0;
	logic reference_source_select_pin = 1'b0;
	pdl_pkg::pdl_ctrl_src_t ctrl_src = 4'h0;
	logic coarse_skew = 1'b0;
	pdl_pkg::pdl_fb_cfg_t fb_cfg = 3'h0;
	logic [7:0] lock_cycles_cfg = 8'h00;
	logic lock_active_high = 1'b1;
	logic lock_pin_en = 1'b0;
	logic [1:0] lock_pin_sel = 2'h0;
	pdl_pkg::pdl_group_route_t [4:0] group_route = 20'h0_0000;
	logic [3:0] div_out;
	logic [9:0] grp_out;
	logic [3:0] pin_out;
	logic [3:0] pin_oe;
	logic fb_clk;
	logic lock_ind;
	logic byp_act;
	logic alt_act;
	logic ph_en;
	logic fb_ph;
	logic fb_tm;
	logic byp_e;
	logic alt_e;
	logic pair_ok;
	int miscompares = 0;
	int compares = 0;
	int seed = 32'h9e75_9193;
	int rises [10];
	wire [9:0] mon = {fb_clk, grp_out[8], grp_out[6], grp_out[4], grp_out[2], grp_out[0], div_out};

	always #4 clk = ~clk;

	pdl_ref_model SRC
	(
		.clk(clk), .reset_n(reset_n), .ref_a(ref_a), .ref_b(ref_b), .fb_ret(fb_ret), .vco(vco)
	);

	pdl_ctrl DUT
	(
		.clk(clk), .reset_n(reset_n), .primary_ref_input(ref_a), .alternate_ref_input(ref_b),
		.fb_return_input(fb_ret), .freq_lock_det(freq_lock_det), .bypass_pin(bypass_pin),
		.reference_source_select_pin(reference_source_select_pin), .vco_tick(vco), .ctrl_src(ctrl_src), .coarse_skew(coarse_skew),
		.fb_cfg(fb_cfg), .lock_cycles_cfg(lock_cycles_cfg), .lock_active_high(lock_active_high),
		.lock_pin_en(lock_pin_en), .lock_pin_sel(lock_pin_sel), .group_route(group_route),
		.div_out_ff(div_out), .group_out_ff(grp_out), .fb_clk_ff(fb_clk), .lock_ind_ff(lock_ind),
		.user_pin_out_ff(pin_out), .user_pin_oe_ff(pin_oe), .bypass_active_ff(byp_act),
		.ref_alt_active_ff(alt_act), .phase_skew_en_ff(ph_en), .fb_phase_skew_en_ff(fb_ph),
		.fb_time_skew_en_ff(fb_tm)
	);

	//////////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		if (miscompares == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(logic [31:0] seen, logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// edge counts may be off by one at the window boundaries
	task automatic near(int c, int e);
		chk(c + 1 >= e && c <= e + 1, 1'b1);
	endtask

	// expected rises in 768 cycles; 0-3 divider k, 4 ref a, 5 ref b, 6 feedback return
	function automatic int expc(int s);
		int base;
		base = byp_e ? (alt_e ? 64 : 96) : 768;
		case (s)
			4: return 96;
			5: return 64;
			6: return 48;
			default: return base >> (s + 1 + coarse_skew);
		endcase
	endfunction

	task automatic rand_run();
		logic [9:0] prev;
		@(negedge clk);
		ctrl_src = 4'($random(seed));
		bypass_pin = 1'($random(seed));
		reference_source_select_pin = 1'($random(seed));
		coarse_skew = 1'($random(seed));
		fb_cfg = 3'($random(seed));
		group_route = 20'($random(seed));
		lock_pin_en = 1'b0;
		byp_e = ctrl_src.bypass_from_port ? ctrl_src.bypass_port : bypass_pin;
		alt_e = ctrl_src.reference_source_select_from_port ? ctrl_src.reference_source_select_port : reference_source_select_pin;
		repeat (8) @(negedge clk);
		chk(byp_act, byp_e);
		chk(alt_act, alt_e);
		chk(ph_en, !byp_e);
		chk(lock_ind, !lock_active_high);
		chk(pin_oe, 4'h0);
		chk(fb_ph, !byp_e);
		chk(fb_tm, fb_cfg.external);
		prev = mon;
		pair_ok = 1'b1;
		foreach (rises[i]) rises[i] = 0;
		repeat (768)
		begin
			@(negedge clk);
			for (int i = 0; i < 10; i++) rises[i] += (prev[i] === 1'b0 && mon[i] === 1'b1);
			for (int g = 0; g < 5; g++) if (grp_out[2*g] !== grp_out[2*g+1]) pair_ok = 1'b0;
			prev = mon;
		end
		for (int k = 0; k < 4; k++) near(rises[k], expc(k));
		for (int g = 0; g < 5; g++)
			near(rises[4+g], expc(group_route[g].use_ref ? 4 + group_route[g].ref_alt :
				group_route[g].div_sel));
		near(rises[9], expc(fb_cfg.external ? 6 : fb_cfg.div_sel));
		chk(pair_ok, 1'b1);
	endtask

	task automatic wait_lock(output int t);
		t = 0;
		while (lock_ind !== lock_active_high && t < 3000)
		begin
			@(negedge clk);
			t++;
		end
		if (t >= 3000)
		begin
			miscompares++;
			summarize();
		end
	endtask

	task automatic lock_run(logic [7:0] c);
		int need;
		int t;
		@(negedge clk);
		ctrl_src = 4'h0;
		bypass_pin = 1'b0;
		reference_source_select_pin = 1'b0;
		lock_cycles_cfg = c;
		// polarity alternates so both levels are exercised whatever the seed
		lock_active_high = !lock_active_high;
		lock_pin_en = 1'b1;
		lock_pin_sel = 2'($random(seed));
		need = (c < 15) ? 16 : c + 1;
		repeat (6) @(negedge clk);
		chk(lock_ind, !lock_active_high);
		freq_lock_det = 1'b1;
		wait_lock(t);
		chk(t >= (need - 1) * 8 && t <= need * 8 + 12, 1'b1);
		chk(pin_out, lock_active_high ? 4'h1 << lock_pin_sel : 4'h0);
		chk(pin_oe, 4'h1 << lock_pin_sel);
		freq_lock_det = 1'b0;
		repeat (3) @(negedge clk);
		chk(lock_ind, !lock_active_high);
		chk(pin_out, lock_active_high ? 4'h0 : 4'h1 << lock_pin_sel);
		freq_lock_det = 1'b1;
		repeat (60) @(negedge clk);
		chk(lock_ind, !lock_active_high);
		wait_lock(t);
		// bypass from the port side while locked
		ctrl_src = 4'hc;
		repeat (4) @(negedge clk);
		chk(lock_ind, !lock_active_high);
		chk(ph_en, 1'b0);
		ctrl_src = 4'h0;
		repeat (60) @(negedge clk);
		chk(lock_ind, !lock_active_high);
		freq_lock_det = 1'b0;
	endtask

	//////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (4) @(negedge clk);
		chk({div_out, grp_out, fb_clk, lock_ind, pin_oe}, 0);
		reset_n = 1'b1;
		repeat (3) @(negedge clk);
		for (int i = 0; i < 12; i++) rand_run();
		// a second reset in mid-run must clear the divider, group, feedback, lock, pin enable, bypass and phase skew outputs again
		reset_n = 1'b0;
		repeat (4) @(negedge clk);
		chk({div_out, grp_out, fb_clk, lock_ind, pin_oe, byp_act, ph_en}, 0);
		reset_n = 1'b1;
		repeat (3) @(negedge clk);
		lock_run(8'h00);
		lock_run(8'h10);
		lock_run(8'hff);
		lock_run(8'($random(seed)));
		summarize();
	end
endmodule
